// ===== hdl/diim_regs.svh
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: 32-bit Avalon-MM word addressing, offsets counted in words
// Notes: definitions only
`ifndef DIIM_REGS_SVH
`define DIIM_REGS_SVH
`define DIIM_CLK_MHZ        50
`define DIIM_FILT_NS        3500
`define DIIM_FILT_CYC       ((`DIIM_FILT_NS * `DIIM_CLK_MHZ + 999) / 1000)
`define DIIM_ADDR_CTRL      4'h0
`define DIIM_ADDR_STATE     4'h1
`define DIIM_ADDR_IMAGE     4'h2
`define DIIM_ADDR_CNT0      4'h3
`define DIIM_ADDR_CNT1      4'h4
`define DIIM_ADDR_IRQ_STAT  4'h5
`define DIIM_ADDR_IRQ_MASK  4'h6
`define DIIM_ADDR_BASE      4'h7
`define DIIM_CTRL_MAP_EN    0
`define DIIM_CTRL_MAP_REG   1
`define DIIM_CTRL_CNT_MAP   2
`define DIIM_CTRL_MODE0_LO  4
`define DIIM_CTRL_MODE1_LO  6
`define DIIM_CTRL_RESET     32'h0000_0000
`define DIIM_IRQ_BITS       6
`define DIIM_FLAG_COUNT     24
`endif

// ===== hdl/diim_pkg.sv
// Purpose: shared types of the digital input image mapper
// Assumes: nothing beyond the header
// Notes: mode codes are positional
package diim_pkg;
  typedef enum logic [1:0] {
    DIIM_STD, DIIM_ENC, DIIM_CNT, DIIM_INT
  } diim_mode_t;
  typedef enum logic [1:0] {
    DIIM_IDLE, DIIM_FLAGS, DIIM_WORD, DIIM_COUNTS
  } diim_state_t;
endpackage

// ===== hdl/diim_top.sv
// Purpose: filters 20 inputs, runs counters/encoders, writes the image
// Assumes: one 50 MHz clock, Avalon-MM slave with waitrequest
// Notes: image writes go out on a simple write port after each cycle start
// What this block does
// - inputs 0..5 serve per selected mode
// - standard inputs filtered, 3.5 us constant
// - two enabled counters up to 30 kHz
// - two encoders with A, B and index
// - interrupt mode gives four interrupt inputs
// - mode chosen per group 0-2, 3-5
// - reset leaves both groups standard
// - image copied cyclically only when enabled
// - flag x+n holds input n
// - flags 20 to 23 written zero
// - word bit n holds input n
// - word bits 20 to 31 zero
// - inputs 1 and 4 enable up counting
// - inputs 2 and 5 stay standard
// - counters written at y and y+1
`include "diim_regs.svh"
module diim_top #(
  parameter int N_IN     = 20,
  parameter int FILT_CYC = `DIIM_FILT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [19:0] digital_input,
  input  wire logic        cycle_start,
  output logic             first_cyclic_program_block,
  output logic             image_wr,
  output logic [15:0]      image_addr,
  output logic [31:0]      image_data,
  output logic             image_is_flag,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  if (N_IN != 20 || FILT_CYC < 1) begin : g_bad_param
    $error("diim_top: unsupported parameters");
  end

  localparam int FW = $clog2(FILT_CYC + 1);

  // input synchronisers and filters
  logic [N_IN-1:0] s1, s2, s3, filt;
  logic [N_IN-1:0] next_filt;
  logic [FW-1:0]   fcnt [N_IN];
  logic [FW-1:0]   next_fcnt [N_IN];

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= digital_input;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_filt
      always_comb begin
        next_filt[gi] = filt[gi];
        next_fcnt[gi] = '0;
        if (s2[gi] == s3[gi] && s3[gi] != filt[gi]) begin
          if (fcnt[gi] == FW'(FILT_CYC - 1))
            next_filt[gi] = s3[gi];
          else
            next_fcnt[gi] = fcnt[gi] + FW'(1);
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
          filt[gi] <= 1'b0;
          fcnt[gi] <= '0;
        end else begin
          filt[gi] <= next_filt[gi];
          fcnt[gi] <= next_fcnt[gi];
        end
      end
    end
  endgenerate

  // registers
  logic [31:0] ctrl, irq_stat, irq_mask, base;
  logic [31:0] next_ctrl, next_irq_stat, next_irq_mask, next_base;
  diim_pkg::diim_mode_t mode0, mode1;
  assign mode0 = diim_pkg::diim_mode_t'(ctrl[`DIIM_CTRL_MODE0_LO +: 2]);
  assign mode1 = diim_pkg::diim_mode_t'(ctrl[`DIIM_CTRL_MODE1_LO +: 2]);

  // counters and encoders
  logic [31:0] cnt0, cnt1, next_cnt0, next_cnt1;
  logic [N_IN-1:0] prev, next_prev;

  function automatic logic [31:0] diim_step(
    input diim_pkg::diim_mode_t m, input logic [31:0] c,
    input logic a, input logic b, input logic idx,
    input logic pa, input logic pb, input logic en);
    logic [31:0] r;
    r = c;
    if (m == diim_pkg::DIIM_CNT) begin
      if (en && a && !pa)
        r = c + 32'h0000_0001;
    end else if (m == diim_pkg::DIIM_ENC) begin
      if (idx)
        r = 32'h0000_0000;
      else if (a != pa || b != pb)
        r = ((a ^ pb) ? c + 32'h0000_0001 : c - 32'h0000_0001);
    end
    return r;
  endfunction

  always_comb begin
    next_prev = filt;
    next_cnt0 = diim_step(mode0, cnt0, filt[0], filt[1], filt[2],
                          prev[0], prev[1], filt[1]);
    next_cnt1 = diim_step(mode1, cnt1, filt[3], filt[4], filt[5],
                          prev[3], prev[4], filt[4]);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cnt0 <= '0;
      cnt1 <= '0;
      prev <= '0;
    end else begin
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      prev <= next_prev;
    end
  end

  // interrupt events: rising edges in interrupt-mode groups
  logic [5:0] ev;
  always_comb begin
    ev = '0;
    if (mode0 == diim_pkg::DIIM_INT)
      ev[1:0] = filt[1:0] & ~prev[1:0];
    if (mode1 == diim_pkg::DIIM_INT)
      ev[4:3] = filt[4:3] & ~prev[4:3];
  end

  // image copy sequencer
  diim_pkg::diim_state_t st, next_st;
  logic [31:0] snap, next_snap;
  logic [4:0]  idx, next_idx;
  logic        next_wr, next_flag, next_fcpb;
  logic [15:0] next_addr;
  logic [31:0] next_data;

  always_comb begin
    next_st = st;
    next_snap = snap;
    next_idx = idx;
    next_wr = 1'b0;
    next_flag = 1'b0;
    next_addr = image_addr;
    next_data = image_data;
    next_fcpb = 1'b0;
    unique case (st)
      diim_pkg::DIIM_IDLE: begin
        if (cycle_start) begin
          next_snap = {12'h000, filt};
          next_idx = '0;
          if (!ctrl[`DIIM_CTRL_MAP_EN] && !ctrl[`DIIM_CTRL_CNT_MAP])
            next_fcpb = 1'b1;
          else if (!ctrl[`DIIM_CTRL_MAP_EN])
            next_st = diim_pkg::DIIM_COUNTS;
          else if (ctrl[`DIIM_CTRL_MAP_REG])
            next_st = diim_pkg::DIIM_WORD;
          else
            next_st = diim_pkg::DIIM_FLAGS;
        end
      end
      diim_pkg::DIIM_FLAGS: begin
        next_wr = 1'b1;
        next_flag = 1'b1;
        next_addr = base[15:0] + {11'h000, idx};
        next_data = {31'h0, snap[idx]};
        next_idx = idx + 5'h01;
        if (idx == 5'(`DIIM_FLAG_COUNT - 1)) begin
          next_idx = '0;
          next_st = ctrl[`DIIM_CTRL_CNT_MAP] ? diim_pkg::DIIM_COUNTS
                                               : diim_pkg::DIIM_IDLE;
          next_fcpb = !ctrl[`DIIM_CTRL_CNT_MAP];
        end
      end
      diim_pkg::DIIM_WORD: begin
        next_wr = 1'b1;
        next_addr = base[15:0];
        next_data = snap;
        next_st = ctrl[`DIIM_CTRL_CNT_MAP] ? diim_pkg::DIIM_COUNTS
                                             : diim_pkg::DIIM_IDLE;
        next_fcpb = !ctrl[`DIIM_CTRL_CNT_MAP];
      end
      diim_pkg::DIIM_COUNTS: begin
        next_wr = 1'b1;
        next_addr = base[31:16] + {11'h000, idx};
        next_data = idx[0] ? cnt1 : cnt0;
        next_idx = idx + 5'h01;
        if (idx[0]) begin
          next_st = diim_pkg::DIIM_IDLE;
          next_fcpb = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      st <= diim_pkg::DIIM_IDLE;
      snap <= '0;
      idx <= '0;
      image_wr <= 1'b0;
      image_is_flag <= 1'b0;
      image_addr <= '0;
      image_data <= '0;
      first_cyclic_program_block <= 1'b0;
    end else begin
      st <= next_st;
      snap <= next_snap;
      idx <= next_idx;
      image_wr <= next_wr;
      image_is_flag <= next_flag;
      image_addr <= next_addr;
      image_data <= next_data;
      first_cyclic_program_block <= next_fcpb;
    end
  end

  // bus slave: one wait state on reads, writes take effect at once
  logic rd_ack, next_rd_ack;
  logic [31:0] next_rdata;
  assign avs_waitrequest = avs_read && !rd_ack;

  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    next_base = base;
    next_irq_stat = irq_stat;
    if (avs_write) begin
      unique case (avs_address)
        `DIIM_ADDR_CTRL:     next_ctrl = avs_writedata;
        `DIIM_ADDR_IRQ_MASK: next_irq_mask = avs_writedata;
        `DIIM_ADDR_BASE:     next_base = avs_writedata;
        `DIIM_ADDR_IRQ_STAT: next_irq_stat = irq_stat & ~avs_writedata;
        default: ;
      endcase
    end
    next_irq_stat = (next_irq_stat | {26'h0, ev}) & 32'h0000_003F;
    next_rd_ack = avs_read && !rd_ack;
    unique case (avs_address)
      `DIIM_ADDR_CTRL:     next_rdata = ctrl;
      `DIIM_ADDR_STATE:    next_rdata = {12'h000, filt};
      `DIIM_ADDR_IMAGE:    next_rdata = snap;
      `DIIM_ADDR_CNT0:     next_rdata = cnt0;
      `DIIM_ADDR_CNT1:     next_rdata = cnt1;
      `DIIM_ADDR_IRQ_STAT: next_rdata = irq_stat;
      `DIIM_ADDR_IRQ_MASK: next_rdata = irq_mask;
      `DIIM_ADDR_BASE:     next_rdata = base;
      default:             next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl <= `DIIM_CTRL_RESET;
      irq_stat <= '0;
      irq_mask <= '0;
      base <= '0;
      rd_ack <= 1'b0;
      avs_readdata <= '0;
    end else begin
      ctrl <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      base <= next_base;
      rd_ack <= next_rd_ack;
      avs_readdata <= next_rdata;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // checks
  a_flag_tail_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b) image_wr && image_is_flag
    && image_addr >= base[15:0] + 16'h0014 |-> image_data == 32'h0000_0000)
    else $error("flag past input 19 not zero");
  a_word_top_zero: assert property (@(posedge ref_clk)
    disable iff (!rst_b) image_wr && !image_is_flag
    && st == diim_pkg::DIIM_IDLE && !ctrl[`DIIM_CTRL_CNT_MAP]
    |-> image_data[31:20] == 12'h000) else $error("word bits 20-31 not zero");
  a_no_map_off: assert property (@(posedge ref_clk)
    disable iff (!rst_b) st == diim_pkg::DIIM_IDLE && cycle_start
    && !ctrl[0] && !ctrl[2] |=> !image_wr && first_cyclic_program_block)
    else $error("image written while disabled");
  a_cnt_needs_en: assert property (@(posedge ref_clk)
    disable iff (!rst_b) mode0 == diim_pkg::DIIM_CNT && !filt[1]
    && $stable(mode0) |=> cnt0 == $past(cnt0))
    else $error("counter 0 moved without enable");
  a_cnt_edge: assert property (@(posedge ref_clk)
    disable iff (!rst_b) mode1 == diim_pkg::DIIM_CNT && filt[4] && filt[3]
    && !prev[3] |=> cnt1 == $past(cnt1) + 32'h0000_0001)
    else $error("counter 1 missed edge");
  a_filt_hold: assert property (@(posedge ref_clk)
    disable iff (!rst_b) $changed(filt[0]) |-> $past(s3[0]) == filt[0])
    else $error("filter changed without stable input");
  a_reset_std: assert property (@(posedge ref_clk)
    !$past(rst_b) |-> mode0 == diim_pkg::DIIM_STD
    && mode1 == diim_pkg::DIIM_STD)
    else $error("mode not standard after reset");
  a_int_sticky: assert property (@(posedge ref_clk)
    disable iff (!rst_b) ev[0] |=> irq_stat[0])
    else $error("interrupt event lost");
  a_std_no_count: assert property (@(posedge ref_clk)
    disable iff (!rst_b) mode0 == diim_pkg::DIIM_STD && $stable(mode0)
    |=> cnt0 == $past(cnt0))
    else $error("counter ran in standard mode");
endmodule

// ===== tb/diim_field_model.sv
// Purpose: field wiring and program memory image beside the mapper
// Assumes: one clock; image writes taken at the rising edge
// Notes: inputs follow the level the bench asks for
module diim_field_model (
  input  wire logic        ref_clk,
  input  wire logic [19:0] field_level,
  output logic      [19:0] digital_input,
  input  wire logic        image_wr,
  input  wire logic [15:0] image_addr,
  input  wire logic [31:0] image_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] image_mem [0:255];
  assign digital_input = field_level;
  always @(posedge ref_clk) begin
    if (image_wr === 1'b1) begin
      image_mem[image_addr[7:0]] <= image_data;
    end
  end
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench of the input image mapper
// Assumes: filter shortened to 4 cycles
// Notes: image writes checked against a queue of expected words
`include "diim_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FILT = 4;
  logic        ref_clk, rst_b, cycle_start, first_cyclic_program_block;
  logic        image_wr, image_is_flag, irq, avs_read, avs_write;
  logic        avs_waitrequest, exp_flag;
  logic [19:0] lvl, dig, v;
  logic [15:0] image_addr;
  logic [31:0] image_data, avs_readdata, avs_writedata, rd;
  logic [3:0]  avs_address;
  logic [47:0] exp_q[$];
  int          bad_count, n_tests;
  diim_top #(.FILT_CYC(FILT)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
    .digital_input(dig), .cycle_start(cycle_start),
    .first_cyclic_program_block(first_cyclic_program_block),
    .image_wr(image_wr), .image_addr(image_addr), .image_data(image_data),
    .image_is_flag(image_is_flag), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  diim_field_model u_field (.ref_clk(ref_clk), .field_level(lvl),
    .digital_input(dig), .image_wr(image_wr), .image_addr(image_addr),
    .image_data(image_data));
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    n_tests++;
    if (seen !== want) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] want);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    check({16'h0, rd}, {16'h0, want});
  endtask
  task automatic settle();
    repeat (FILT + 8) @(posedge ref_clk);
  endtask
  task automatic pulse(input int b);
    lvl[b] <= 1'b1;
    settle();
    lvl[b] <= 1'b0;
    settle();
  endtask
  task automatic run_cycle();
    int k;
    @(posedge ref_clk);
    cycle_start <= 1'b1;
    @(posedge ref_clk);
    cycle_start <= 1'b0;
    k = 0;
    while (first_cyclic_program_block !== 1'b1 && k < 100) begin
      @(posedge ref_clk);
      k++;
    end
    // last write and done pulse share an edge; let the monitor pop first
    @(negedge ref_clk);
    check(48'(k < 100), 48'h1);
    check(48'(exp_q.size()), 48'h0);
  endtask
  // pops the oldest expected image write
  always @(posedge ref_clk) begin
    if (image_wr === 1'b1) begin
      check({47'h0, image_is_flag}, {47'h0, exp_flag});
      if (exp_q.size() == 0) begin
        check({image_addr, image_data}, ~{image_addr, image_data});
      end else begin
        check({image_addr, image_data}, exp_q.pop_front());
      end
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // run needs well under 10k cycles
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    rst_b = 1'b0;
    cycle_start = 1'b0;
    lvl = 20'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    exp_flag = 1'b0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(32'hC5F3));
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(`DIIM_ADDR_CTRL, `DIIM_CTRL_RESET);
    rd_chk(4'hF, 32'h0);
    for (int m = 0; m < 4; m++) begin
      bus_wr(`DIIM_ADDR_CTRL, 32'((m << 4) | ((3 - m) << 6)));
      rd_chk(`DIIM_ADDR_CTRL, 32'((m << 4) | ((3 - m) << 6)));
    end
    bus_wr(`DIIM_ADDR_CTRL, 32'h0);
    v = 20'($urandom());
    lvl <= v;
    settle();
    rd_chk(`DIIM_ADDR_STATE, {12'h000, v});
    lvl <= v ^ 20'h00001;
    repeat (2) @(posedge ref_clk);
    lvl <= v;
    settle();
    rd_chk(`DIIM_ADDR_STATE, {12'h000, v});
    bus_wr(`DIIM_ADDR_BASE, 32'h0040_0010);
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_0001);
    exp_flag <= 1'b1;
    for (int n = 0; n < 24; n++) begin
      exp_q.push_back({16'h0010 + 16'(n), 31'h0, n < 20 ? v[n] : 1'b0});
    end
    run_cycle();
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_0003);
    exp_flag <= 1'b0;
    exp_q.push_back({16'h0010, 12'h000, v});
    run_cycle();
    check({16'h0, u_field.image_mem[8'h10]}, {16'h0, 12'h000, v});
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_0002);
    run_cycle();
    lvl <= 20'h00006;
    settle();
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_00A0);
    repeat (3) pulse(0);
    repeat (2) pulse(3);
    rd_chk(`DIIM_ADDR_CNT0, 32'h3);
    rd_chk(`DIIM_ADDR_CNT1, 32'h0);
    lvl[4] <= 1'b1;
    settle();
    pulse(3);
    rd_chk(`DIIM_ADDR_CNT1, 32'h1);
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_00A7);
    exp_q.push_back({16'h0010, 32'h0000_0016});
    exp_q.push_back({16'h0040, 32'h0000_0003});
    exp_q.push_back({16'h0041, 32'h0000_0001});
    run_cycle();
    lvl <= 20'h0;
    settle();
    // encoder on group 0: index clears, then two forward steps
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_0010);
    lvl <= 20'h00004;
    settle();
    lvl <= 20'h0;
    settle();
    lvl <= 20'h00001;
    settle();
    lvl <= 20'h00003;
    settle();
    rd_chk(`DIIM_ADDR_CNT0, 32'h2);
    lvl <= 20'h0;
    settle();
    bus_wr(`DIIM_ADDR_CTRL, 32'h0000_0030);
    bus_wr(`DIIM_ADDR_IRQ_STAT, 32'h0000_003F);
    lvl <= 20'h00001;
    settle();
    rd_chk(`DIIM_ADDR_IRQ_STAT, 32'h1);
    check({47'h0, irq}, 48'h0);
    bus_wr(`DIIM_ADDR_IRQ_MASK, 32'h1);
    @(posedge ref_clk);
    check({47'h0, irq}, 48'h1);
    bus_wr(`DIIM_ADDR_IRQ_STAT, 32'h1);
    @(posedge ref_clk);
    check({47'h0, irq}, 48'h0);
    rd_chk(`DIIM_ADDR_IRQ_STAT, 32'h0);
    end_of_test();
  end
endmodule
